// *** rtl/pfsc_checker.v ***
// Purpose: checks encoder frame schedule and decoder capability for a paging link
// Assumes: placement strobes come from same-clock logic; frame_i marks a frame edge
// Notes: four address slots, chosen by slot_i; registers on a plain strobe port
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pfsc_consts.vh"
module pfsc_checker
(
    // clock and reset
    input wire mclk_i,
    input wire reset_i,
    // register port
    input wire [`PFSC_ADDR_W-1:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    // frame and placement stream
    input wire frame_i,
    input wire place_i,
    input wire [`PFSC_IDX_W-1:0] slot_i,
    input wire temp_i,
    input wire temp_setup_i,
    input wire [2:0] vector_type_code_i,
    input wire [1:0] message_subtype_i,
    input wire [2:0] instruction_subtype_i,
    input wire frag_i,
    input wire first_i,
    input wire last_i,
    input wire char_split_i,
    input wire num_en_i,
    input wire [`PFSC_MSGNUM_W-1:0] num_i,
    input wire retrieved_i,
    input wire missed_flag_i,
    input wire [1:0] rate_i,
    input wire levels_i,
    // results
    output reg accept_o,
    output reg irq_o
);
    // control, sticky status, mask
    reg [7:0] ctrl;
    reg [`PFSC_ST_W-1:0] status;
    reg [`PFSC_ST_W-1:0] mask;
    reg [15:0] frame_count;
    reg [`PFSC_ST_W-1:0] next_event;
    reg [`PFSC_SLOTS-1:0] temp_busy;
    reg next_accept;
    // slot state buses
    wire [2*`PFSC_SLOTS-1:0] uses_bus;
    wire [`PFSC_SLOTS-1:0] open_bus;
    wire [`PFSC_CNT_W*`PFSC_SLOTS-1:0] gap_bus;
    wire [`PFSC_SLOTS-1:0] nv_bus;
    wire [`PFSC_MSGNUM_W*`PFSC_SLOTS-1:0] num_bus;
    // decode of the selected slot, used for every slot enable
    function sel;
        input [`PFSC_IDX_W-1:0] s;
        input integer k;
        begin
            sel = (s == k[`PFSC_IDX_W-1:0]);
        end
    endfunction
    // one slot per tracked address, each with its own last message number register
    genvar g;
    generate
        for (g = 0; g < `PFSC_SLOTS; g = g + 1)
        begin : g_slot
            pfsc_slot u_slot
            (
                .mclk_i(mclk_i),
                .reset_i(reset_i),
                .hit_i(place_i && sel(slot_i, g)),
                .frame_i(frame_i),
                .frag_i(frag_i),
                .last_i(last_i),
                .num_en_i(num_en_i && !temp_i),
                .num_i(num_i),
                .uses_o(uses_bus[2*g+1:2*g]),
                .fragopen_o(open_bus[g]),
                .gap_o(gap_bus[`PFSC_CNT_W*g+`PFSC_CNT_W-1:`PFSC_CNT_W*g]),
                .numvalid_o(nv_bus[g]),
                .lastnum_o(num_bus[`PFSC_MSGNUM_W*g+`PFSC_MSGNUM_W-1:`PFSC_MSGNUM_W*g])
            );
        end
    endgenerate
    // selected slot view
    wire [1:0] s_uses = uses_bus[2*slot_i +: 2];
    wire s_open = open_bus[slot_i];
    wire [`PFSC_CNT_W-1:0] s_gap = gap_bus[`PFSC_CNT_W*slot_i +: `PFSC_CNT_W];
    wire s_nv = nv_bus[slot_i];
    wire [`PFSC_MSGNUM_W-1:0] s_num = num_bus[`PFSC_MSGNUM_W*slot_i +: `PFSC_MSGNUM_W];
    // spacing limit picked by service configuration
    wire [`PFSC_CNT_W-1:0] space_lim = ctrl[`PFSC_CTRL_LONGSPACE] ? `PFSC_SPACE_LONG : `PFSC_SPACE_SHORT;
    // numeric codes that must fit one frame
    wire is_numeric = (vector_type_code_i == `PFSC_VEC_NUM) || (vector_type_code_i == `PFSC_VEC_NUMS) ||
        (vector_type_code_i == `PFSC_VEC_NUMN);
    // decoder capability: implied vector support follows from configured types
    wire cap_num = ctrl[`PFSC_CTRL_NUM] || ctrl[`PFSC_CTRL_ALPHA];
    wire cap_short = cap_num;
    wire cap_instr = ctrl[`PFSC_CTRL_ANYPHASE] && ctrl[`PFSC_CTRL_ALPHA];
    reg vec_ok;
    // one scheme bit means exactly two addressing schemes exist
    wire anyphase = ctrl[`PFSC_CTRL_ANYPHASE];
    // only four rate and level pairs are legal; rate 1=1600,2=3200,3=6400
    wire mode_ok = ((rate_i == 2'h1) && (levels_i == `PFSC_LEVELS_2)) || (rate_i == 2'h2) ||
        ((rate_i == 2'h3) && (levels_i == `PFSC_LEVELS_4));
    // vector acceptance decode
    always @*
    begin
        vec_ok = 1'b0;
        case (vector_type_code_i)
            `PFSC_VEC_SHORT: vec_ok = cap_short && (message_subtype_i == `PFSC_SUB_ZERO2);
            `PFSC_VEC_INSTR: vec_ok = cap_instr && (instruction_subtype_i == `PFSC_SUB_ZERO3);
            `PFSC_VEC_ALPHA: vec_ok = ctrl[`PFSC_CTRL_ALPHA];
            default: vec_ok = is_numeric && cap_num;
        endcase
    end
    // violation events for the current placement
    always @*
    begin
        next_event = {`PFSC_ST_W{1'b0}};
        next_accept = 1'b0;
        if (place_i)
        begin
            // limit across all phases: counts are per frame, not per phase
            if (!frag_i && !temp_i && (s_uses >= 2'h2))
                next_event[`PFSC_ST_REPEAT] = 1'b1;
            if (frag_i && first_i && s_open)
                next_event[`PFSC_ST_FRAGSTART] = 1'b1;
            if (!frag_i && s_open && (s_uses >= 2'h1))
                next_event[`PFSC_ST_FRAGREP] = 1'b1;
            if (temp_i && ((s_uses >= 2'h1) || (temp_busy[slot_i] && first_i)))
                next_event[`PFSC_ST_TEMPREUSE] = 1'b1;
            if (temp_i && temp_setup_i)
                next_event[`PFSC_ST_TEMPNEST] = 1'b1;
            if (frag_i && is_numeric)
                next_event[`PFSC_ST_NUMFRAG] = 1'b1;
            // open run kept alive up to space_lim: one minute, or four minutes with the long-spacing bit set
            if (frag_i && !first_i && s_open && (s_gap > space_lim))
                next_event[`PFSC_ST_SPACING] = 1'b1;
            if (frag_i && char_split_i)
                next_event[`PFSC_ST_CHARSPLIT] = 1'b1;
            if (ctrl[`PFSC_CTRL_NUMBERING] && num_en_i && !temp_i && !retrieved_i && s_nv &&
                (num_i <= s_num))
                next_event[`PFSC_ST_SEQ] = 1'b1;
            if (temp_i && num_en_i)
                next_event[`PFSC_ST_TEMPNUM] = 1'b1;
            if (retrieved_i && missed_flag_i)
                next_event[`PFSC_ST_RETRIEVE] = 1'b1;
            next_accept = vec_ok && mode_ok;
        end
    end
    // temp address busy from first use until its message ends
    always @(posedge mclk_i)
    begin
        if (reset_i)
            temp_busy <= {`PFSC_SLOTS{1'b0}};
        else if (place_i && temp_i)
            temp_busy[slot_i] <= !(last_i || !frag_i);
    end
    // register writes, sticky status with set winning over clear
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            ctrl <= `PFSC_CTRL_RESET;
            status <= {`PFSC_ST_W{1'b0}};
            mask <= {`PFSC_ST_W{1'b0}};
            frame_count <= 16'h0000;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `PFSC_REG_CTRL)
                ctrl <= reg_wdata_i[7:0];
            if (reg_wr_i && reg_addr_i == `PFSC_REG_MASK)
                mask <= reg_wdata_i[`PFSC_ST_W-1:0];
            if (reg_wr_i && reg_addr_i == `PFSC_REG_STATUS)
                status <= (status & ~reg_wdata_i[`PFSC_ST_W-1:0]) | next_event;
            else
                status <= status | next_event;
            if (frame_i)
                frame_count <= frame_count + 16'h0001;
        end
    end
    // read data one cycle after strobe, outputs registered
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            reg_rdata_o <= 16'h0000;
            accept_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            accept_o <= next_accept;
            irq_o <= |(status & mask);
            reg_rdata_o <= 16'h0000;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    `PFSC_REG_CTRL: reg_rdata_o <= {8'h00, ctrl};
                    `PFSC_REG_STATUS: reg_rdata_o <= {5'h00, status};
                    `PFSC_REG_MASK: reg_rdata_o <= {5'h00, mask};
                    `PFSC_REG_CAPS: reg_rdata_o <= {12'h000, cap_instr, cap_short, cap_num, anyphase};
                    `PFSC_REG_FRAME: reg_rdata_o <= frame_count;
                    default: reg_rdata_o <= 16'h0000; // unmapped reads zero
                endcase
            end
        end
    end
endmodule // pfsc_checker

// *** rtl/pfsc_consts.vh ***
// Purpose: shared constants of the pager frame schedule checker
// Assumes: included by its bare name
// Notes: definitions only
`ifndef PFSC_CONSTS_VH
`define PFSC_CONSTS_VH
// register offsets (word addresses on the plain port)
`define PFSC_ADDR_W 4
`define PFSC_REG_CTRL 4'h0
`define PFSC_REG_STATUS 4'h1
`define PFSC_REG_MASK 4'h2
`define PFSC_REG_CAPS 4'h3
`define PFSC_REG_FRAME 4'h4
// ctrl fields
`define PFSC_CTRL_ANYPHASE 0
`define PFSC_CTRL_NUM 1
`define PFSC_CTRL_ALPHA 2
`define PFSC_CTRL_LONGSPACE 3
`define PFSC_CTRL_NUMBERING 4
`define PFSC_CTRL_RESET 8'h00
// vector type codes
`define PFSC_VEC_INSTR 3'h1
`define PFSC_VEC_SHORT 3'h2
`define PFSC_VEC_NUM 3'h3
`define PFSC_VEC_NUMS 3'h4
`define PFSC_VEC_ALPHA 3'h5
`define PFSC_VEC_NUMN 3'h7
`define PFSC_SUB_ZERO2 2'h0
`define PFSC_SUB_ZERO3 3'h0
// status bits (one per violation class)
`define PFSC_ST_W 11
`define PFSC_ST_REPEAT 0
`define PFSC_ST_FRAGSTART 1
`define PFSC_ST_FRAGREP 2
`define PFSC_ST_TEMPREUSE 3
`define PFSC_ST_TEMPNEST 4
`define PFSC_ST_NUMFRAG 5
`define PFSC_ST_SPACING 6
`define PFSC_ST_CHARSPLIT 7
`define PFSC_ST_SEQ 8
`define PFSC_ST_TEMPNUM 9
`define PFSC_ST_RETRIEVE 10
// table and timing
`define PFSC_SLOTS 4
`define PFSC_IDX_W 2
`define PFSC_MSGNUM_W 6
`define PFSC_CNT_W 8
`define PFSC_CNT_ONE 8'h01
`define PFSC_CNT_ZERO 8'h00
`define PFSC_SPACE_SHORT 8'h20
`define PFSC_SPACE_LONG 8'h80
`define PFSC_FRAME_MS 1875
`define PFSC_TOL_MIN 4
`define PFSC_FRAMES_PER_MIN 32
`define PFSC_LEVELS_2 1'b0
`define PFSC_LEVELS_4 1'b1
`endif

// *** rtl/pfsc_slot.v ***
// Purpose: one per-address tracking slot: frame use counts, fragment state, number sequence
// Assumes: requests come from logic on mclk_i
// Notes: the top checks the returned state; this slot only remembers
`timescale 1ns/1ps
`include "pfsc_consts.vh"
module pfsc_slot
(
    // clock and reset
    input wire mclk_i,
    input wire reset_i,
    // update request
    input wire hit_i,
    input wire frame_i,
    input wire frag_i,
    input wire last_i,
    input wire num_en_i,
    input wire [`PFSC_MSGNUM_W-1:0] num_i,
    // state
    output reg [1:0] uses_o,
    output reg fragopen_o,
    output reg [`PFSC_CNT_W-1:0] gap_o,
    output reg numvalid_o,
    output reg [`PFSC_MSGNUM_W-1:0] lastnum_o
);
    // per-frame counter saturates at three; gap counts frames since last fragment
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            uses_o <= 2'h0;
            fragopen_o <= 1'b0;
            gap_o <= `PFSC_CNT_ZERO;
            numvalid_o <= 1'b0;
            lastnum_o <= {`PFSC_MSGNUM_W{1'b0}};
        end
        else
        begin
            if (frame_i)
            begin
                // new frame clears uses; gap ages while a fragment is open
                uses_o <= 2'h0;
                if (fragopen_o && gap_o != {`PFSC_CNT_W{1'b1}})
                    gap_o <= gap_o + `PFSC_CNT_ONE;
            end
            else if (hit_i)
            begin
                if (!frag_i && uses_o != 2'h3)
                    uses_o <= uses_o + 2'h1;
                if (frag_i)
                begin
                    fragopen_o <= !last_i;
                    gap_o <= `PFSC_CNT_ZERO;
                end
                if (num_en_i)
                begin
                    numvalid_o <= 1'b1;
                    lastnum_o <= num_i;
                end
            end
        end
    end
endmodule // pfsc_slot

// *** tb/pfsc_checker_assertions.sv ***
// Purpose: port-level properties of the schedule checker
// Assumes: one clock, sync active-high reset
// Notes: bound to every pfsc_checker instance
`timescale 1ns/1ps
`include "pfsc_consts.vh"
module pfsc_checker_assertions
(
    // clock and reset
    input wire mclk_i,
    input wire reset_i,
    // register port
    input wire [`PFSC_ADDR_W-1:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // placements and results
    input wire place_i,
    input wire accept_o,
    input wire irq_o
);
    // single domain, so one clocking and one disable
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    AST_RST: assert property ($fell(reset_i) |-> !irq_o && !accept_o) else $error("outputs set after reset");
    AST_RDIDLE: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("read data without read");
    AST_UNMAP: assert property (reg_rd_i && reg_addr_i > 4'h4 |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
    AST_STWID: assert property (reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o[15:11] == 5'h00) else $error("status width");
    AST_MASKRB: assert property (reg_wr_i && reg_addr_i == 4'h2 ##2 reg_rd_i && reg_addr_i == 4'h2
        |=> reg_rdata_o[10:0] == $past(reg_wdata_i[10:0], 3)) else $error("mask readback");
    AST_ACC: assert property (!place_i |=> !accept_o) else $error("accept without placement");
    AST_IRQHOLD: assert property (!reg_wr_i ##1 irq_o |=> irq_o) else $error("irq dropped without write");
    AST_IRQCAUSE: assert property ($rose(irq_o) |-> $past(place_i, 2) || $past(reg_wr_i, 2)) else $error("irq uncaused");
endmodule // pfsc_checker_assertions
bind pfsc_checker pfsc_checker_assertions u_chk (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .place_i(place_i), .accept_o(accept_o), .irq_o(irq_o));

// *** tb/pfsc_enc_model.sv ***
// Purpose: paging terminal stand-in feeding frame edges and placements
// Assumes: tasks are called from the bench
// Notes: breaks a schedule rule only when the caller asks it to
`timescale 1ns/1ps
module pfsc_enc_model
(
    // clock
    input wire mclk_i,
    // placement stream
    output reg frame_o,
    output reg place_o,
    output reg [1:0] slot_o,
    output reg [2:0] vec_o,
    output reg [8:0] flags_o,
    output reg [5:0] num_o,
    // air mode as {levels, rate}
    output reg [2:0] mode_o
);
    // the four decodable rate and level pairs, stepped per placement
    localparam logic [2:0] MODES [4] = '{3'h1, 3'h2, 3'h6, 3'h7};
    int m = 0;
    initial
    begin
        {frame_o, place_o, slot_o, vec_o, flags_o, num_o} = 22'h000000;
        mode_o = 3'h1;
    end
    // placement legal unless the caller asks otherwise
    task place(input [1:0] s, input [2:0] v, input [8:0] f, input [5:0] n);
        begin
            @(posedge mclk_i);
            {place_o, slot_o, vec_o, flags_o, num_o} <= {1'b1, s, v, f, n};
            mode_o <= MODES[m % 4];
            m = m + 1;
            @(posedge mclk_i);
            place_o <= 1'b0;
            // qualifiers are not held once released
            flags_o <= ~f;
        end
    endtask
    task frame;
        begin
            @(posedge mclk_i);
            frame_o <= 1'b1;
            @(posedge mclk_i);
            frame_o <= 1'b0;
        end
    endtask
endmodule // pfsc_enc_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the schedule checker
// Assumes: encoder model drives placements, tasks drive registers
// Notes: status expectations come from a behavioural model
`timescale 1ns/1ps
module tb_top;
    reg mclk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    reg [3:0] reg_addr_i = 4'h0;
    reg [15:0] reg_wdata_i = 16'h0000, rdat;
    reg [10:0] msk = 11'h000;
    wire [15:0] reg_rdata_o;
    wire frm, plc, accept_o, irq_o;
    wire [1:0] slt;
    wire [2:0] vec, mode;
    wire [8:0] flg;
    wire [5:0] num;
    int n_errors = 0, tests_run = 0, seed = 90, want_st = 0, lim = 32, nfr = 0, i, j, k;
    int uses [4] = '{0, 0, 0, 0}, tuses [4] = '{0, 0, 0, 0}, gap [4] = '{0, 0, 0, 0};
    int lastn [4] = '{0, 0, 0, 0}, open [4] = '{0, 0, 0, 0}, nv [4] = '{0, 0, 0, 0};
    pfsc_checker uut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .frame_i(frm), .place_i(plc),
        .slot_i(slt), .temp_i(flg[0]), .temp_setup_i(flg[1]), .vector_type_code_i(vec), .message_subtype_i(2'h0),
        .instruction_subtype_i(3'h0), .frag_i(flg[2]), .first_i(flg[3]), .last_i(flg[4]), .char_split_i(flg[5]),
        .num_en_i(flg[6]), .num_i(num), .retrieved_i(flg[7]), .missed_flag_i(flg[8]), .rate_i(mode[1:0]),
        .levels_i(mode[2]), .accept_o(accept_o), .irq_o(irq_o));
    pfsc_enc_model enc (.mclk_i(mclk_i), .frame_o(frm), .place_o(plc), .slot_o(slt), .vec_o(vec), .flags_o(flg),
        .num_o(num), .mode_o(mode));
    always #5 mclk_i = ~mclk_i;
    task chk(input [15:0] seen, input [15:0] want);
        begin
            tests_run = tests_run + 1;
            if (seen !== want)
            begin
                n_errors = n_errors + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task results;
        begin
            $display("compares %0d mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge mclk_i);
            {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
            @(posedge mclk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge mclk_i);
            {reg_rd_i, reg_addr_i} <= {1'b1, a};
            @(posedge mclk_i);
            reg_rd_i <= 1'b0;
            #1 rdat = reg_rdata_o;
        end
    endtask
    task ebit(input int b, input c);
        if (c)
            want_st = want_st | (1 << b);
    endtask
    // model first, then the placement; f = {missed, retr, num, split, last, first, frag, setup, temp}
    task pl(input [1:0] s, input [2:0] v, input [8:0] f, input [5:0] n);
        begin
            tuses[s] = tuses[s] + f[0];
            uses[s] = uses[s] + (!f[0] && !f[2]);
            ebit(0, !f[0] && !f[2] && uses[s] > 2);
            ebit(1, f[2] && f[3] && open[s]);
            ebit(2, !f[0] && !f[2] && open[s] && uses[s] > 1);
            ebit(3, f[0] && tuses[s] > 1);
            ebit(4, f[0] && f[1]);
            ebit(5, f[2] && (v == 3 || v == 4 || v == 7));
            ebit(6, f[2] && !f[3] && gap[s] > lim);
            ebit(7, f[2] && f[5]);
            ebit(8, f[6] && !f[0] && !f[7] && nv[s] && n <= lastn[s]);
            ebit(9, f[0] && f[6]);
            ebit(10, f[7] && f[8]);
            gap[s] = f[2] ? 0 : gap[s];
            open[s] = f[2] ? (f[3] || open[s]) && !f[4] : open[s];
            nv[s] = nv[s] | (f[6] && !f[0]);
            lastn[s] = (f[6] && !f[0]) ? n : lastn[s];
            enc.place(s, v, f, n);
            #1 chk({15'h0000, accept_o}, {15'h0000, v != 3'h0 && v != 3'h6});
        end
    endtask
    task fr;
        begin
            enc.frame;
            nfr = nfr + 1;
            for (int q = 0; q < 4; q++)
            begin
                uses[q] = 0;
                tuses[q] = 0;
                gap[q] = gap[q] + open[q];
            end
        end
    endtask
    // status and irq against the model, then clear and start a new frame
    task st;
        begin
            rd(4'h1);
            chk(rdat, want_st[15:0]);
            chk({15'h0000, irq_o}, {15'h0000, |(want_st[10:0] & msk)});
            wr(4'h1, 16'h07ff);
            want_st = 0;
            fr;
            $display("step done at %0t", $time);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        wr(4'h0, 16'h0017);
        repeat (2) pl(0, 2, 9'h000, 0);
        st;
        repeat (3) pl(0, 2, 9'h000, 0);
        st;
        msk = 11'h7ff;
        wr(4'h2, 16'h07ff);
        rd(4'h2);
        chk(rdat, 16'h07ff);
        for (i = 1; i < 8; i++)
        begin
            pl(1, i[2:0], (i == 6) ? 9'h01c : 9'h03c, 0);
            st;
        end
        repeat (2) pl(2, 5, 9'h00c, 0);
        st;
        repeat (2) pl(2, 2, 9'h000, 0);
        pl(2, 5, 9'h014, 0);
        st;
        pl(0, 2, 9'h180, 0);
        pl(0, 2, 9'h080, 0);
        st;
        for (i = 0; i < 12; i++)
        begin
            k = $random(seed) & 3;
            pl(k[1:0], 2, 9'h040, (nv[k] ? lastn[k] : 0) + 1 + ($random(seed) & 3));
            fr;
        end
        st;
        pl(k[1:0], 2, 9'h040, lastn[k][5:0]);
        st;
        for (j = 0; j < 2; j++)
        begin
            lim = j ? 128 : 32;
            wr(4'h0, j ? 16'h001f : 16'h0017);
            pl(3, 5, 9'h00c, 0);
            repeat (lim) fr;
            pl(3, 5, 9'h004, 0);
            repeat (lim + 1) fr;
            pl(3, 5, 9'h014, 0);
            st;
        end
        pl(3, 2, 9'h001, 0);
        pl(3, 2, 9'h043, 0);
        st;
        rd(4'hf);
        chk(rdat, 16'h0000);
        rd(4'h4);
        chk({8'h00, rdat[7:0]}, {8'h00, nfr[7:0]});
        results;
    end
    // hang guard, well past the under one thousand cycles the run needs
    initial
    begin
        #400000;
        n_errors = n_errors + 1;
        results;
    end
endmodule // tb_top
